// [verilog/ipec_params.svh]
// constants for the pending, enable, threshold and claim block
`ifndef IPEC_PARAMS_SVH
`define IPEC_PARAMS_SVH
`define IPEC_OFF_PEND0 32'h0c001000
`define IPEC_OFF_PEND1 32'h0c001004
`define IPEC_OFF_EN0 32'h0c002000
`define IPEC_OFF_EN1 32'h0c002004
`define IPEC_OFF_THRESH 32'h0c200000
`define IPEC_OFF_CLAIM 32'h0c200004
`define IPEC_NUM_SRC 52
`define IPEC_PRIO_W 3
`define IPEC_ID_W 6
`define IPEC_THRESH_MAX 3'h7
`define IPEC_WORD1_BITS 21
`define IPEC_EN_RST 1'h0
`define IPEC_THRESH_RST 3'h0
`endif

// [verilog/ipec_pkg.sv]
// types for the pending, enable, threshold and claim block
package ipec_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ipec_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } ipec_rsp_t;
  typedef enum logic [1:0] {ipec_idle, ipec_claimed} ipec_gw_t;
endpackage : ipec_pkg

// [verilog/ipec_select.sv]
// priority arbiter: best pending enabled source, lowest id breaks ties
`timescale 1ns/1ns
`default_nettype none
`include "ipec_params.svh"
module ipec_select import ipec_pkg::*; #(
  parameter int NSRC = `IPEC_NUM_SRC,
  parameter int PW = `IPEC_PRIO_W,
  parameter int IW = `IPEC_ID_W
) (
  // candidates
  input wire logic [NSRC:1] cand,
  input wire logic [NSRC*PW-1:0] prio,
  // result
  output logic [IW-1:0] best_id,
  output logic [PW-1:0] best_prio
);
  always_comb begin
    best_id = '0;
    best_prio = '0;
    // strict greater keeps lowest id on a tie
    for (int i = 1; i <= NSRC; i++) begin
      if (cand[i] && prio[i*PW-1 -: PW] > best_prio) begin
        best_id = IW'(i);
        best_prio = prio[i*PW-1 -: PW];
      end
    end
  end
endmodule : ipec_select
`default_nettype wire

// [verilog/ipec_core.sv]
// pending, enable, threshold and claim/complete logic for one hart
`timescale 1ns/1ns
`default_nettype none
`include "ipec_params.svh"
// Summary of operation
// - pending flags read as two words, source n at bit n%32 of word n/32
// - bit zero of pending word zero always reads zero
// - pending is read only; word one holds sources 32..52, rest reserved
// - pending clears only by enable then claim; no write path
// - enables held in two words packed like pending
// - enable bit zero is read only zero
// - enable word one bits 0..20 writable, upper bits read zero
// - threshold is three bit field, upper bits read zero
// - sources with priority at or below threshold are masked
// - claim read returns best pending enabled id or zero
// - claim read clears pending flag of returned id atomically
// - claim served any time, even without interrupt request
// - claim selection ignores threshold
// - completion id not compared with last claimed id
// - completion for source not enabled is silently dropped
// - equal priorities resolved by lowest id first
// - priority zero never interrupts; one lowest, seven highest
module ipec_core import ipec_pkg::*; #(
  parameter int NSRC = `IPEC_NUM_SRC,
  parameter int PW = `IPEC_PRIO_W,
  parameter int IW = `IPEC_ID_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register access from the hart
  input wire ipec_req_t req,
  output ipec_rsp_t rsp,
  // interrupt sources and their priorities
  input wire logic [NSRC:1] src,
  input wire logic [NSRC*PW-1:0] src_prio,
  // hart notification
  output logic ext_irq_pending_flag
);
  logic [NSRC:1] pend_q;
  logic [NSRC:1] busy_q;
  logic [NSRC:1] en_q;
  logic [PW-1:0] thresh_q;
  ipec_rsp_t rsp_q;
  logic irq_q;
  logic [IW-1:0] best_id;
  logic [PW-1:0] best_prio;
  logic [63:0] pend_w;
  logic [63:0] en_w;
  logic claim_rd;
  logic done_wr;
  logic [IW-1:0] done_id;
  logic done_ok;

  assign pend_w = {{(63-NSRC){1'b0}}, pend_q, 1'b0};
  assign en_w = {{(63-NSRC){1'b0}}, en_q, 1'b0};
  assign claim_rd = req.rd && req.addr == `IPEC_OFF_CLAIM;
  assign done_wr = req.wr && req.addr == `IPEC_OFF_CLAIM;
  assign done_id = req.wdata[IW-1:0];
  // an id beyond the source range or zero names no enabled source
  assign done_ok = done_wr && req.wdata[31:IW] == '0 && done_id != '0 &&
                   int'(done_id) <= NSRC && en_w[done_id];

  // selection looks at pending and enable only, never the threshold
  ipec_select #(.NSRC(NSRC), .PW(PW), .IW(IW)) u_sel (
    .cand(pend_q & en_q),
    .prio(src_prio),
    .best_id(best_id),
    .best_prio(best_prio)
  );

  // gateway per source: level sets pending unless claimed and not done
  genvar g;
  generate
    for (g = 1; g <= NSRC; g++) begin : gw
      logic clr_claim;
      logic clr_done;
      assign clr_claim = claim_rd && int'(best_id) == g;
      assign clr_done = done_ok && int'(done_id) == g;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pend_q[g] <= 1'b0;
        end else if (clr_claim) begin
          pend_q[g] <= 1'b0;
        end else if (src[g] && !busy_q[g]) begin
          pend_q[g] <= 1'b1;
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          busy_q[g] <= 1'b0;
        end else if (clr_claim) begin
          busy_q[g] <= 1'b1;
        end else if (clr_done) begin
          busy_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // enables: full word writes, bit zero and upper word bits dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      en_q <= {NSRC{`IPEC_EN_RST}};
    end else if (req.wr && req.addr == `IPEC_OFF_EN0) begin
      en_q[31:1] <= req.wdata[31:1];
    end else if (req.wr && req.addr == `IPEC_OFF_EN1) begin
      en_q[NSRC:32] <= req.wdata[NSRC-32:0];
    end
  end

  // threshold keeps only the legal low bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      thresh_q <= `IPEC_THRESH_RST;
    end else if (req.wr && req.addr == `IPEC_OFF_THRESH) begin
      thresh_q <= req.wdata[PW-1:0];
    end
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack <= req.rd || req.wr;
      if (!req.rd) begin
        rsp_q.rdata <= '0;
      end else if (req.addr == `IPEC_OFF_PEND0) begin
        rsp_q.rdata <= pend_w[31:0];
      end else if (req.addr == `IPEC_OFF_PEND1) begin
        rsp_q.rdata <= pend_w[63:32];
      end else if (req.addr == `IPEC_OFF_EN0) begin
        rsp_q.rdata <= en_w[31:0];
      end else if (req.addr == `IPEC_OFF_EN1) begin
        rsp_q.rdata <= en_w[63:32];
      end else if (req.addr == `IPEC_OFF_THRESH) begin
        rsp_q.rdata <= {{(32-PW){1'b0}}, thresh_q};
      end else if (claim_rd) begin
        rsp_q.rdata <= {{(32-IW){1'b0}}, best_id};
      end else begin
        rsp_q.rdata <= '0;
      end
    end
  end

  // notification: some enabled pending source above threshold
  logic irq_d;
  always_comb begin
    irq_d = 1'b0;
    for (int i = 1; i <= NSRC; i++) begin
      if (pend_q[i] && en_q[i] &&
          src_prio[i*PW-1 -: PW] > thresh_q) begin
        irq_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign rsp = rsp_q;
  assign ext_irq_pending_flag = irq_q;

  // checks
  claim_clears_a: assert property (@(posedge clock) disable iff (rst)
    claim_rd && best_id != '0 |=> !pend_q[$past(best_id)])
    else $error("claimed source still pending");
  claim_data_a: assert property (@(posedge clock) disable iff (rst)
    claim_rd |=> rsp.rdata == {{(32-IW){1'b0}}, $past(best_id)})
    else $error("claim read data wrong");
  pend_bit0_a: assert property (@(posedge clock) disable iff (rst)
    req.rd && req.addr == `IPEC_OFF_PEND0 |=> !rsp.rdata[0])
    else $error("pending bit zero set");
  en_upper_a: assert property (@(posedge clock) disable iff (rst)
    req.rd && req.addr == `IPEC_OFF_EN1 |=> rsp.rdata[31:21] == '0)
    else $error("enable upper bits nonzero");
  thresh_upper_a: assert property (@(posedge clock) disable iff (rst)
    req.rd && req.addr == `IPEC_OFF_THRESH |=> rsp.rdata[31:3] == '0)
    else $error("threshold upper bits nonzero");
  irq_thresh_a: assert property (@(posedge clock) disable iff (rst)
    thresh_q == `IPEC_THRESH_MAX && $stable(thresh_q)
    |=> !ext_irq_pending_flag)
    else $error("interrupt above max threshold");
  irq_follow_a: assert property (@(posedge clock) disable iff (rst)
    ##1 ext_irq_pending_flag == $past(irq_d))
    else $error("interrupt request mismatch");
  busy_hold_a: assert property (@(posedge clock) disable iff (rst)
    busy_q[3] && !pend_q[3] && !(done_ok && done_id == IW'(3))
    |=> !pend_q[3])
    else $error("claimed source pending again");
  done_ignored_a: assert property (@(posedge clock) disable iff (rst)
    done_wr && !done_ok && busy_q[40] |=> busy_q[40])
    else $error("disabled completion took effect");
  claim_nz_c: cover property (@(posedge clock) claim_rd && best_id != '0);
  claim_zero_c: cover property (@(posedge clock) claim_rd && best_id == '0);
  done_c: cover property (@(posedge clock) done_ok);
  irq_c: cover property (@(posedge clock) $rose(ext_irq_pending_flag));
endmodule : ipec_core
`default_nettype wire

// [tb/ipec_hart.sv]
// hart model issuing word accesses to the block
`timescale 1ns/1ns
`default_nettype none
module ipec_hart import ipec_pkg::*; (
  // clock
  input wire logic clock,
  // register bus
  output ipec_req_t req,
  input wire ipec_rsp_t rsp
);
  initial req = '0;
  // one-cycle strobe, whole 32-bit word, answer stands for the next cycle
  task automatic acc(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q, output logic k);
    @(negedge clock);
    req.rd = !w;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(negedge clock);
    q = rsp.rdata;
    k = rsp.ack;
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : acc
endmodule : ipec_hart
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the claim/complete block
`timescale 1ns/1ns
`default_nettype none
`include "ipec_params.svh"
module tb;
  import ipec_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [52:1] src = '0;
  logic [155:0] prio = '0;
  logic irq;
  ipec_req_t req;
  ipec_rsp_t rsp;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] q;
  logic k;
  always #2 clock = ~clock;
  ipec_core uut (.clock(clock), .rst(rst), .req(req), .rsp(rsp),
    .src(src), .src_prio(prio), .ext_irq_pending_flag(irq));
  ipec_hart hart (.clock(clock), .req(req), .rsp(rsp));
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic rc(input logic [31:0] a, e);
    hart.acc(1'b0, a, 32'h0, q, k);
    chk({31'h0, k}, 32'h1);
    chk(q, e);
  endtask : rc
  task automatic wr(input logic [31:0] a, d);
    hart.acc(1'b1, a, d, q, k);
    chk({31'h0, k}, 32'h1);
  endtask : wr
  task automatic fl(input logic e);
    repeat (3) @(negedge clock);
    chk({31'h0, irq}, {31'h0, e});
  endtask : fl
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic t_regs();
    rc(`IPEC_OFF_EN0, 32'h0);
    wr(`IPEC_OFF_EN0, 32'hffffffff);
    rc(`IPEC_OFF_EN0, 32'hfffffffe);
    wr(`IPEC_OFF_EN1, 32'hffffffff);
    rc(`IPEC_OFF_EN1, 32'h001fffff);
    wr(`IPEC_OFF_THRESH, 32'hffffffff);
    rc(`IPEC_OFF_THRESH, 32'h7);
    wr(`IPEC_OFF_PEND0, 32'hffffffff);
    rc(`IPEC_OFF_PEND0, 32'h0);
    rc(32'h0c001008, 32'h0);
  endtask : t_regs
  task automatic t_claim();
    @(negedge clock);
    prio[8:6] = 3'h5;
    prio[29:27] = 3'h2;
    prio[119:117] = 3'h5;
    src[1] = 1'b1;
    src[3] = 1'b1;
    src[10] = 1'b1;
    src[40] = 1'b1;
    fl(1'b0);
    rc(`IPEC_OFF_PEND0, 32'h0000040a);
    rc(`IPEC_OFF_PEND1, 32'h00000100);
    rc(`IPEC_OFF_CLAIM, 32'd3);
    rc(`IPEC_OFF_PEND0, 32'h00000402);
    rc(`IPEC_OFF_CLAIM, 32'd40);
    rc(`IPEC_OFF_CLAIM, 32'd10);
    rc(`IPEC_OFF_CLAIM, 32'd0);
  endtask : t_claim
  task automatic t_complete();
    wr(`IPEC_OFF_THRESH, 32'h4);
    fl(1'b0);
    wr(`IPEC_OFF_CLAIM, 32'd3);
    fl(1'b1);
    wr(`IPEC_OFF_THRESH, 32'h5);
    fl(1'b0);
    wr(`IPEC_OFF_EN1, 32'h0);
    wr(`IPEC_OFF_CLAIM, 32'd40);
    wr(`IPEC_OFF_EN1, 32'hffffffff);
    rc(`IPEC_OFF_PEND1, 32'h0);
    wr(`IPEC_OFF_CLAIM, 32'd10);
    repeat (2) @(negedge clock);
    rc(`IPEC_OFF_PEND0, 32'h0000040a);
  endtask : t_complete
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_claim();
    t_complete();
    summarize();
  end
endmodule : tb
`default_nettype wire
